// File: gdio_port.sv
// four pin general digital io port: direction, output value,
// pull-up, toggle by write, break-before-make and input sync
// assumes a register master on mclk and pads outside the chip
// pad levels enter through a falling edge stage and a rising edge stage
// only the driver enable and pull-up enable clear without a clock
// reserved data bits read zero and are ignored on write
//
// Implementation choices: strobed register access and the address map.
`timescale 1ns/10ps

module gdio_port
   import gdio_pkg::*;
(
   input wire logic mclk, // system clock
   input wire logic rstn, // reset, low active
   input wire logic [gdio_pkg::GDIO_AW-1:0] reg_addr, // register offset
   input wire logic [gdio_pkg::GDIO_DW-1:0] reg_wdata, // write data
   input wire logic reg_wr, // write strobe
   input wire logic reg_rd, // read strobe
   output logic [gdio_pkg::GDIO_DW-1:0] reg_rdata, // read data, next cycle
   input wire logic [gdio_pkg::GDIO_PINS-1:0] pad_in, // pad level
   output logic [gdio_pkg::GDIO_PINS-1:0] pad_out, // pad drive value
   output logic [gdio_pkg::GDIO_PINS-1:0] pad_oe, // pad driver enable
   output logic [gdio_pkg::GDIO_PINS-1:0] pad_pullup, // pull-up enable
   input wire logic sleep_clamp, // deep sleep clamp request
   input wire logic [gdio_pkg::GDIO_PINS-1:0] ext_int_en // pin used as ext irq
);

   import gdio_pkg::*;

   // widen a pin vector onto the data bus
   function automatic logic [GDIO_DW-1:0] gdio_widen(input gdio_pins_t v);
      logic [GDIO_DW-1:0] w;
      w = '0;
      w[GDIO_PINS-1:0] = v;
      return w;
   endfunction : gdio_widen

   // write decode for one offset
   function automatic logic gdio_hit(
      input logic wr,
      input logic [GDIO_AW-1:0] a,
      input logic [GDIO_AW-1:0] ofs
   );
      return wr && (a == ofs);
   endfunction : gdio_hit

   // driver enable for one pin from the direction held now and about to load
   function automatic logic gdio_oe_pin(
      input logic dir_now,
      input logic dir_new,
      input logic bbm_on
   );
      logic oe;
      if (!dir_new) begin
         // release at once, break-before-make or not
         oe = 1'b0;
      end else if (bbm_on && !dir_now) begin
         // fresh output: hold tri-state for this one cycle
         oe = 1'b0;
      end else begin
         oe = 1'b1;
      end
      return oe;
   endfunction : gdio_oe_pin

   // level seen by the input stage for one pin
   function automatic logic gdio_clamp_pin(
      input logic lvl,
      input logic clamp_on,
      input logic irq_pin,
      input logic clamp_lvl
   );
      logic v;
      v = lvl;
      if (clamp_on && !irq_pin) begin
         // releasing this on a high pin is seen as a change
         v = clamp_lvl;
      end
      return v;
   endfunction : gdio_clamp_pin

   // register state
   // held values behind offsets 0, 1, 2 and 4
   gdio_pins_t dir_reg;
   gdio_pins_t dir_next;
   gdio_pins_t out_reg;
   gdio_pins_t out_next;
   gdio_pins_t pull_reg;
   gdio_pins_t pull_next;
   logic bbm_reg;
   logic bbm_next;

   // pad driver state
   // lags a rising direction bit by a cycle only under break-before-make
   gdio_pins_t oe_reg;
   gdio_pins_t oe_next;

   // input path state
   // clamped level, falling edge stage, input register bits
   gdio_pins_t din_clamped;
   gdio_pins_t sync_low_reg;
   gdio_pins_t in_reg;

   // read data state
   // cleared whenever no read strobe was seen
   logic [GDIO_DW-1:0] rdata_reg;
   logic [GDIO_DW-1:0] rdata_next;

   // write decode
   logic wr_dir;
   logic wr_out;
   logic wr_pull;
   logic wr_in;
   logic wr_ctrl;

   // one strobe at a time, so the toggle and the value write never meet;
   // unmapped offsets decode to nothing and are dropped
   assign wr_dir = gdio_hit(reg_wr, reg_addr, GDIO_OFS_DIR);
   assign wr_out = gdio_hit(reg_wr, reg_addr, GDIO_OFS_OUT);
   assign wr_pull = gdio_hit(reg_wr, reg_addr, GDIO_OFS_PULL);
   assign wr_in = gdio_hit(reg_wr, reg_addr, GDIO_OFS_IN);
   assign wr_ctrl = gdio_hit(reg_wr, reg_addr, GDIO_OFS_CTRL);

   // next values of the software registers
   // every register holds unless its own offset is written; the output value also changes on a write to offset 3
   // a toggle write reads the held value, not the pad level
   always_comb begin
      dir_next = dir_reg;
      out_next = out_reg;
      pull_next = pull_reg;
      bbm_next = bbm_reg;
      if (wr_dir) begin
         dir_next = reg_wdata[GDIO_PINS-1:0];
      end
      if (wr_out) begin
         out_next = reg_wdata[GDIO_PINS-1:0];
      end
      if (wr_in) begin
         // ones invert, zeros keep; direction does not matter
         out_next = out_reg ^ reg_wdata[GDIO_PINS-1:0];
      end
      if (wr_pull) begin
         // output low with pull-up is not blocked here
         pull_next = reg_wdata[GDIO_PINS-1:0];
      end
      if (wr_ctrl) begin
         bbm_next = reg_wdata[GDIO_CTRL_BBM_BIT];
      end
   end

   // software registers, cleared by reset
   // these need a clock to clear; the pads stay safe meanwhile
   // because the driver enable clears on its own
   always_ff @(posedge mclk) begin
      if (!rstn) begin
         dir_reg <= GDIO_RST_DIR;
         out_reg <= GDIO_RST_OUT;
         bbm_reg <= GDIO_RST_BBM;
      end else begin
         dir_reg <= dir_next;
         out_reg <= out_next;
         bbm_reg <= bbm_next;
      end
   end

   // driver enable next value
   // compares the direction about to load with the one held now:
   // a rising bit with break-before-make on gives one tri-state cycle,
   // a falling bit drops the driver at the same edge as the direction;
   // direction changes in back-to-back cycles cannot skip the hold
   always_comb begin
      oe_next = '0;
      for (int i = 0; i < GDIO_PINS; i++) begin
         oe_next[i] = gdio_oe_pin(dir_reg[i], dir_next[i], bbm_reg);
      end
   end

   // driver enable, cleared without waiting for a clock edge
   // a stopped clock must not leave a pin driving while reset is low
   // the reset branch loads a constant only
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         oe_reg <= GDIO_RST_DIR;
      end else begin
         oe_reg <= oe_next;
      end
   end

   // pull-up enables, forced off under reset asynchronously
   // an unused pin kept up by its pull-up floats while reset is low
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         pull_reg <= GDIO_RST_PULL;
      end else begin
         pull_reg <= pull_next;
      end
   end

   // clamp ahead of the input stage during deep sleep
   // floating or mid-rail pads then cost no current in the input buffer
   // interrupt pins stay open so they can still wake the chip
   always_comb begin
      din_clamped = pad_in;
      for (int i = 0; i < GDIO_PINS; i++) begin
         din_clamped[i] = gdio_clamp_pin(pad_in[i], sleep_clamp, ext_int_en[i],
                                         GDIO_CLAMP_LVL[i]);
      end
   end

   // first stage: value held from the falling clock edge
   // stands in for a latch open while the clock is high: both hand the
   // level present at the fall to the rising edge stage
   // only the second stage reads this flop
   always_ff @(negedge mclk) begin
      if (!rstn) begin
         sync_low_reg <= GDIO_RST_IN;
      end else begin
         sync_low_reg <= din_clamped;
      end
   end

   // second stage: input bits load on the rising edge
   // a pad change lands here half to one and a half cycles later,
   // depending on where in the cycle it arrives
   always_ff @(posedge mclk) begin
      if (!rstn) begin
         in_reg <= GDIO_RST_IN;
      end else begin
         // a pad driven from out_reg arrives one cycle later
         in_reg <= sync_low_reg;
      end
   end

   // read data mux, unmapped offsets read zero
   // reserved bits above the pins always read zero
   always_comb begin
      rdata_next = GDIO_RST_RDATA;
      if (reg_rd) begin
         case (reg_addr)
            GDIO_OFS_DIR: begin
               rdata_next = gdio_widen(dir_reg);
            end
            GDIO_OFS_OUT: begin
               rdata_next = gdio_widen(out_reg);
            end
            GDIO_OFS_PULL: begin
               rdata_next = gdio_widen(pull_reg);
            end
            GDIO_OFS_IN: begin
               rdata_next = gdio_widen(in_reg);
            end
            GDIO_OFS_CTRL: begin
               rdata_next = GDIO_RST_RDATA;
               rdata_next[GDIO_CTRL_BBM_BIT] = bbm_reg;
            end
            default: begin
               rdata_next = GDIO_RST_RDATA;
            end
         endcase
      end
   end

   // read data register, valid only in the cycle after the strobe
   // the master takes the data in that cycle; it never waits
   always_ff @(posedge mclk) begin
      if (!rstn) begin
         rdata_reg <= GDIO_RST_RDATA;
      end else begin
         rdata_reg <= rdata_next;
      end
   end

   // outputs straight from flip-flops
   // no logic between the registers and the pads avoids glitches
   assign reg_rdata = rdata_reg;
   assign pad_out = out_reg;
   assign pad_oe = oe_reg;
   assign pad_pullup = pull_reg;

endmodule : gdio_port

// File: gdio_pkg.sv
// constants for the general digital io port
// assumes one clock and a byte wide register port
package gdio_pkg;

   // port geometry
   localparam int GDIO_PINS = 4;
   localparam int GDIO_DW = 8;
   localparam int GDIO_AW = 3;

   // register offsets
   localparam logic [2:0] GDIO_OFS_DIR = 3'h0;
   localparam logic [2:0] GDIO_OFS_OUT = 3'h1;
   localparam logic [2:0] GDIO_OFS_PULL = 3'h2;
   localparam logic [2:0] GDIO_OFS_IN = 3'h3;
   localparam logic [2:0] GDIO_OFS_CTRL = 3'h4;

   // control register field
   localparam int GDIO_CTRL_BBM_BIT = 0;

   // reset values
   localparam logic [3:0] GDIO_RST_DIR = 4'h0;
   localparam logic [3:0] GDIO_RST_OUT = 4'h0;
   localparam logic [3:0] GDIO_RST_PULL = 4'h0;
   localparam logic [3:0] GDIO_RST_IN = 4'h0;
   localparam logic GDIO_RST_BBM = 1'b0;
   localparam logic [7:0] GDIO_RST_RDATA = 8'h00;

   // clamp level for a sleeping input
   localparam logic [3:0] GDIO_CLAMP_LVL = 4'h0;

   // pin state type
   typedef logic [GDIO_PINS-1:0] gdio_pins_t;

endpackage : gdio_pkg

// File: gdio_port_properties.sv
// timing checks on the ports of the digital io port
// assumes one clock and a low active reset
`timescale 1ns/10ps
module gdio_chk (
   input wire logic mclk, rstn, reg_wr, reg_rd, sleep_clamp, // clock, reset, strobes
   input wire logic [2:0] reg_addr, // offset
   input wire logic [7:0] reg_wdata, reg_rdata, // data
   input wire logic [3:0] pad_in, pad_out, pad_oe, pad_pullup, ext_int_en // pins
);
   default clocking @(posedge mclk); endclocking
   default disable iff (!rstn);
   // direction write decode
   wire w0 = reg_wr && reg_addr == 3'h0;
   property p_out; reg_wr && reg_addr == 3'h1 |=> pad_out == $past(reg_wdata[3:0]); endproperty
   a_out: assert property (p_out) else $error("pad value not written");
   property p_tog;
      reg_wr && reg_addr == 3'h3 |=> pad_out == ($past(pad_out) ^ $past(reg_wdata[3:0]));
   endproperty
   a_tog: assert property (p_tog) else $error("toggle wrong");
   property p_pull; reg_wr && reg_addr == 3'h2 |=> pad_pullup == $past(reg_wdata[3:0]); endproperty
   a_pull: assert property (p_pull) else $error("pull-up wrong");
   property p_off; w0 |=> (pad_oe & ~$past(reg_wdata[3:0])) == 4'h0; endproperty
   a_off: assert property (p_off) else $error("driver not released");
   property p_oe_src; |(pad_oe & ~$past(pad_oe)) |-> $past(w0) || $past(w0, 2); endproperty
   a_oe_src: assert property (p_oe_src) else $error("driver on without cause");
   property p_idle; !reg_rd |=> reg_rdata == 8'h00; endproperty
   a_idle: assert property (p_idle) else $error("read data not idle");
   property p_rd_out; reg_rd && reg_addr == 3'h1 |=> reg_rdata == {4'h0, $past(pad_out)}; endproperty
   a_rd_out: assert property (p_rd_out) else $error("value readback wrong");
   property p_pin;
      reg_rd && reg_addr == 3'h3 && $past(rstn) && !sleep_clamp && !$past(sleep_clamp)
         && $stable(pad_in) |=> reg_rdata == {4'h0, $past(pad_in)};
   endproperty
   a_pin: assert property (p_pin) else $error("pin read wrong");
   c_oe: cover property (pad_oe != $past(pad_oe));
   c_slp: cover property (reg_rd && reg_addr == 3'h3 && sleep_clamp);
   c_bbm: cover property (reg_wr && reg_addr == 3'h4 && reg_wdata[0]);
endmodule : gdio_chk
bind gdio_port gdio_chk u_chk (.mclk, .rstn, .reg_wr, .reg_rd, .sleep_clamp, .reg_addr,
   .reg_wdata, .reg_rdata, .pad_in, .pad_out, .pad_oe, .pad_pullup, .ext_int_en);

// File: gdio_pad_model.sv
// pads outside the chip: drivers, pull-ups and bench drive
// where the bench and the port both drive a pin, the port driver wins
`timescale 1ns/10ps
module gdio_pad_model (
   input wire logic mclk, // clock for floating noise
   input wire logic [3:0] pad_out, pad_oe, pad_pullup, ext_en, ext_val, // drivers
   output logic [3:0] pad_in // resolved level
);
   logic [3:0] flt;
   // an undriven pin without pull-up wanders
   always_ff @(posedge mclk) flt <= (flt === 4'h5) ? 4'ha : 4'h5;
   // resolve each pin
   always_comb begin
      for (int i = 0; i < 4; i++) begin
         pad_in[i] = pad_oe[i] ? pad_out[i] : ext_en[i] ? ext_val[i] : pad_pullup[i] | flt[i];
      end
   end
endmodule : gdio_pad_model

// File: tb_general_digital_io_port.sv
// self-checking bench for the digital io port
// assumes the pad model and the bound checker
`timescale 1ns/10ps
module tb_general_digital_io_port;
   import gdio_pkg::*;
   logic mclk, rstn, reg_wr, reg_rd, sleep_clamp;
   logic [2:0] reg_addr;
   logic [7:0] reg_wdata, reg_rdata, d;
   logic [3:0] pad_in, pad_out, pad_oe, pad_pullup, ext_int_en, ext_en, ext_val, dir, out, pu, t;
   int err_count = 0, checked = 0, seed = 32'hfc39;
   gdio_port uut (.mclk, .rstn, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
      .pad_in, .pad_out, .pad_oe, .pad_pullup, .sleep_clamp, .ext_int_en);
   gdio_pad_model pads (.mclk, .pad_out, .pad_oe, .pad_pullup, .ext_en, .ext_val, .pad_in);
   initial begin mclk = 1'b0; forever #2 mclk = ~mclk; end
   task automatic wr(input logic [2:0] a, input logic [7:0] v);
      @(posedge mclk) begin reg_wr <= 1'b1; reg_addr <= a; reg_wdata <= v; end
      @(posedge mclk) reg_wr <= 1'b0;
   endtask : wr
   task automatic rd(input logic [2:0] a);
      @(posedge mclk) begin reg_rd <= 1'b1; reg_addr <= a; end
      @(posedge mclk) reg_rd <= 1'b0;
      @(negedge mclk) d = reg_rdata;
   endtask : rd
   task automatic chk(input logic [7:0] g, e);
      checked++;
      if (g !== e) begin err_count++; $display("BAD %0t got %h exp %h", $time, g, e); end
   endtask : chk
   // expected pin readback
   function automatic logic [3:0] pin_exp(input logic [3:0] dr, o, ev, en, input logic sl);
      return ((dr & o) | (~dr & ev)) & ~(sl ? ~en : 4'h0);
   endfunction : pin_exp
   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", checked, err_count);
      if (err_count == 0 && checked > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask : tally_and_finish
   // hang guard
   initial begin #20000; err_count++; tally_and_finish(); end
   // main sequence
   initial begin
      rstn = 1'b0; reg_wr = 1'b0; reg_rd = 1'b0; reg_addr = 3'h0; reg_wdata = 8'h00;
      sleep_clamp = 1'b0; ext_int_en = 4'h0; ext_en = 4'hf; ext_val = 4'h0;
      repeat (12) @(posedge mclk);
      rstn <= 1'b1;
      for (int a = 0; a < 8; a++) begin rd(a[2:0]); chk(d, 8'h00); end
      chk({pad_oe, pad_pullup}, 8'h00);
      $display("reset test done");
      repeat (24) begin
         dir = $random(seed); out = $random(seed); t = $random(seed);
         pu = $random(seed) & ~(dir & ~out);
         wr(3'h1, {4'ha, out}); wr(3'h2, {4'h0, pu}); wr(3'h0, {4'h0, dir});
         ext_en <= ~dir; ext_val <= $random(seed);
         rd(3'h0); chk(d, {4'h0, dir});
         rd(3'h2); chk(d, {4'h0, pu});
         chk({pad_oe, pad_pullup}, {dir, pu});
         rd(3'h3); chk(d, {4'h0, pin_exp(dir, out, ext_val, 4'h0, 1'b0)});
         wr(3'h3, {4'h0, t}); rd(3'h1); chk(d, {4'h0, out ^ t});
         chk({pad_out, pad_oe}, {out ^ t, dir});
      end
      $display("random test done");
      wr(3'h0, 8'h0f); ext_en <= 4'h0;
      for (int i = 0; i < 4; i++) begin
         t = $random(seed);
         @(posedge mclk) begin reg_wr <= 1'b1; reg_addr <= 3'h1; reg_wdata <= {4'h0, t}; end
         @(posedge mclk) reg_wr <= 1'b0;
         @(posedge mclk) begin reg_rd <= 1'b1; reg_addr <= 3'h3; end
         @(posedge mclk) reg_rd <= 1'b0;
         @(negedge mclk) chk(reg_rdata, {4'h0, t});
      end
      $display("loopback test done");
      for (int b = 0; b < 2; b++) begin
         wr(3'h4, b[7:0]); wr(3'h0, 8'h00); wr(3'h0, 8'h0f);
         @(negedge mclk) chk({pad_oe, pad_out}, {b ? 4'h0 : 4'hf, t});
         @(negedge mclk) chk({pad_oe, pad_out}, {4'hf, t});
         wr(3'h0, 8'h00);
         @(negedge mclk) chk({pad_oe, pad_out}, {4'h0, t});
      end
      rd(3'h4); chk(d, 8'h01);
      $display("break test done");
      wr(3'h4, 8'h00); ext_en <= 4'hf; ext_val <= 4'hf;
      repeat (8) begin
         @(posedge mclk) begin sleep_clamp <= $random(seed); ext_int_en <= $random(seed); end
         rd(3'h3); chk(d, {4'h0, pin_exp(4'h0, 4'h0, 4'hf, ext_int_en, sleep_clamp)});
      end
      $display("sleep test done");
      wr(3'h2, 8'h0f); wr(3'h0, 8'h0f);
      @(posedge mclk) #1 rstn = 1'b0;
      #1 chk({pad_oe, pad_pullup}, 8'h00);
      repeat (3) @(posedge mclk);
      rstn <= 1'b1;
      rd(3'h0); chk(d, 8'h00);
      $display("async reset test done");
      tally_and_finish();
   end
endmodule : tb_general_digital_io_port
